// ---- verilog/tcp_pkg.sv ----
package tcp_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_RELOAD = 8'hcd; // Reload value, write only
  localparam logic [7:0] IDX_CLKOPT = 8'hd8; // Clock option
  localparam logic [7:0] IDX_MODE   = 8'hda; // Mode control
  localparam logic [7:0] IDX_COUNT  = 8'hdb; // Count value
  localparam logic [7:0] IDX_STATUS = 8'hdc; // Overflow flag and irq enable

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int M_ENB   = 7; // Count enable
  localparam int M_RATE  = 4; // Prescale select, low bit of three
  localparam int M_CKS   = 3; // Clock source select
  localparam int M_ALOAD = 2; // Reload enable
  localparam int M_TONE  = 1; // Tone output enable
  localparam int M_PWM   = 0; // Pulse output enable
  localparam int C_GN    = 1; // Low-power wake enable
  localparam int C_X8    = 2; // Fast clock select
  localparam int C_X8B   = 3; // Second timer fast clock select
  localparam int S_FLAG  = 0; // Overflow flag
  localparam int S_IEN   = 1; // Overflow irq enable
  localparam int S_TONE  = 2; // Tone level, read only
  localparam int S_PWM   = 3; // Pulse level, read only

  // ----------------------------------------------------------------
  // Reset values, boundaries, prescaler exponents
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_RST   = 8'h00;
  localparam logic [2:0] CLKOPT_RST = 3'h0;
  localparam logic [7:0] COUNT_RST  = 8'h00;
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic [7:0] MASK_256   = 8'hff;
  localparam logic [7:0] MASK_64    = 8'h3f;
  localparam logic [7:0] MASK_32    = 8'h1f;
  localparam logic [7:0] MASK_16    = 8'h0f;
  localparam logic [3:0] EXP_FCPU   = 4'h8; // Instruction clock /256 at code 0
  localparam logic [3:0] EXP_FHOSC  = 4'h7; // High oscillator /128 at code 0

  // Shared pin drive: level and enable travel together
  typedef struct packed {
    logic o;
    logic oe;
  } tcp_pin_s;

  // Whole state of the timer
  typedef struct packed {
    logic [7:0]  mode;
    logic [2:0]  clkopt;  // Bits 3:1 of the clock option register
    logic [7:0]  count;
    logic [7:0]  hold;    // Software side of the reload buffer
    logic [7:0]  active;  // Reload value in use
    logic        flag;
    logic        ien;
    logic [7:0]  presc;
    logic        sync1;
    logic        sync2;
    logic        sync3;
    logic        tone;
    logic        pwm;
    logic        wake;
    tcp_pin_s    pin;
    logic        dvalid;
    logic        dwrite;
    logic [7:0]  didx;
    logic [31:0] rdata;
  } tcp_state_s;

endpackage : tcp_pkg

// ---- verilog/tcp_timer.sv ----
`timescale 1ns/1ps

// Operation
// - Mode register: enable, prescale, source, reload, tone, pulse bits; resets zero.
// - Pulse enable drives pulse level on shared pin, else tone or GPIO drives the pin.
// - Tone works only without pulse; pin toggles once per overflow.
// - Outside pulse mode, reload enable selects reload on overflow.
// - Source select picks prescaled internal clock or external event pin.
// - Prescale codes give instruction/256..2 or oscillator/128..1.
// - Count enable stops or runs the counter, one step per count clock.
// - Event counting forces the event pin interrupt flag to zero.
// - Event counting disables the event pin level-change wake-up.
// - Clock option register: wake enable, fast select, second fast select.
// - Fast select picks instruction or oscillator clock; ignored in event mode.
// - Count register resets zero; overflow sets sticky flag until software clears.
// - On overflow with reload active, count loads from reload value.
// - Boundary 256, or in pulse mode on the internal clock 256/64/32/16 by reload and tone bits.
// - Reload writes go to a buffer, taken over at the next overflow.
// - Pulse mode always reloads; reload bit then only picks boundary.
// - Write-only reload register resets zero, supplies value on overflow.
// - Event mode counts each falling edge; wrap from full raises overflow.
// - Overflow requests an interrupt while the irq enable is set.
// - Pulse output high from cycle start until count equals reload.
// - Wake enable keeps timer running and wakes system on overflow.
module tcp_timer (
  input  wire logic             hclk,              // System clock, 250 MHz
  input  wire logic             hresetn,           // Asynchronous reset, active low
  input  wire logic             hsel,              // Slave select
  input  wire logic [31:0]      haddr,             // Byte address
  input  wire logic [1:0]       htrans,            // Transfer type
  input  wire logic             hwrite,            // Write when high
  input  wire logic [2:0]       hsize,             // Transfer size
  input  wire logic [31:0]      hwdata,            // Write data
  input  wire logic             hready,            // Bus ready in
  output logic                  hreadyout,         // Always ready
  output logic                  hresp,             // Always OKAY
  output logic [31:0]           hrdata,            // Read data, registered
  input  wire logic             fcpu_tick,         // Instruction clock pulse
  input  wire logic             event_pin,         // External event input, async
  input  wire logic             event_irq_raw,     // Event pin interrupt from GPIO logic
  input  wire logic             event_wake_raw,    // Event pin level-change wake request
  input  wire logic             low_power_mode,    // System in periodic low-power mode
  input  wire tcp_pkg::tcp_pin_s gpio_pin,         // GPIO drive for the shared pin
  output tcp_pkg::tcp_pin_s     out_pin,           // Shared pin drive, registered
  output logic                  event_pin_irq_flag,// Gated event pin interrupt flag
  output logic                  event_wake_req,    // Gated event pin wake request
  output logic                  overflow_irq,      // Processor interrupt request
  output logic                  wake_req           // Wake pulse from low-power mode
);

  // ----------------------------------------------------------------
  // State and decoded fields
  // ----------------------------------------------------------------
  tcp_pkg::tcp_state_s s_r;
  tcp_pkg::tcp_state_s s_nxt;

  logic       enb;
  logic [2:0] rate;
  logic       cks;
  logic       aload;
  logic       tone_bit;
  logic       pwm_en;
  logic       tone_en;
  logic       x8;
  logic [3:0] pexp;
  logic [7:0] pmask;
  logic       src_tick;
  logic       presc_tick;
  logic       fall;
  logic       tick;
  logic [7:0] bmask;
  logic       ovf;
  logic       reload_on;
  logic       match;
  logic       acc;
  logic       wr_en;
  logic       cnt_wr;
  logic [31:0] rd_word;

  assign enb      = s_r.mode[tcp_pkg::M_ENB];
  assign rate     = s_r.mode[tcp_pkg::M_RATE +: 3];
  assign cks      = s_r.mode[tcp_pkg::M_CKS];
  assign aload    = s_r.mode[tcp_pkg::M_ALOAD];
  assign tone_bit = s_r.mode[tcp_pkg::M_TONE];
  assign pwm_en   = s_r.mode[tcp_pkg::M_PWM];
  assign x8       = s_r.clkopt[tcp_pkg::C_X8 - 1];

  // ----------------------------------------------------------------
  // Count clock selection
  // ----------------------------------------------------------------
  // Prescaler runs free so a new rate takes effect without a restart
  assign src_tick   = x8 ? 1'b1 : fcpu_tick;
  assign pexp       = (x8 ? tcp_pkg::EXP_FHOSC : tcp_pkg::EXP_FCPU) - {1'b0, rate};
  assign pmask      = 8'((9'h001 << pexp) - 9'h001);
  assign presc_tick = src_tick && ((s_r.presc & pmask) == pmask);
  // Only the second and third stages are looked at; first stage is metastable
  assign fall       = s_r.sync3 && !s_r.sync2;
  assign tick       = enb && (cks ? fall : presc_tick);

  // ----------------------------------------------------------------
  // Boundary, overflow and reload choice
  // ----------------------------------------------------------------
  always_comb begin
    if (!pwm_en || cks) begin
      bmask = tcp_pkg::MASK_256;
    end else begin
      case ({aload, tone_bit})
        2'b00:   bmask = tcp_pkg::MASK_256;
        2'b01:   bmask = tcp_pkg::MASK_64;
        2'b10:   bmask = tcp_pkg::MASK_32;
        2'b11:   bmask = tcp_pkg::MASK_16;
        default: bmask = tcp_pkg::MASK_256;
      endcase
    end
  end

  assign ovf       = tick && ((s_r.count & bmask) == bmask);
  assign reload_on = pwm_en || aload;
  assign tone_en   = tone_bit && !pwm_en;
  assign match     = enb && ((s_r.count & bmask) == (s_r.active & bmask));

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Zero wait states: read data is fetched in the address phase
  assign acc    = hsel && hready && htrans[1] && (hsize == 3'h2);
  assign wr_en  = s_r.dvalid && s_r.dwrite;
  assign cnt_wr = wr_en && (s_r.didx == tcp_pkg::IDX_COUNT);

  always_comb begin
    case (haddr[9:2])
      tcp_pkg::IDX_MODE:   rd_word = {24'h0, s_r.mode};
      tcp_pkg::IDX_CLKOPT: rd_word = {28'h0, s_r.clkopt, 1'b0};
      tcp_pkg::IDX_COUNT:  rd_word = {24'h0, s_r.count};
      tcp_pkg::IDX_STATUS: rd_word = {28'h0, s_r.pwm, s_r.tone, s_r.ien, s_r.flag};
      default:             rd_word = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt       = s_r;
    s_nxt.sync1 = event_pin;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.sync3 = s_r.sync2;
    if (src_tick) begin
      s_nxt.presc = s_r.presc + 8'h01;
    end
    s_nxt.dvalid = acc;
    s_nxt.dwrite = hwrite;
    s_nxt.didx   = haddr[9:2];
    s_nxt.rdata  = acc ? rd_word : 32'h0;

    // Idle timer keeps the live reload equal to the buffer
    if (!enb) begin
      s_nxt.active = s_r.hold;
    end
    if (tick) begin
      s_nxt.count = s_r.count + 8'h01;
    end
    if (ovf) begin
      s_nxt.active = s_r.hold;
      s_nxt.tone   = !s_r.tone;
      if (reload_on) begin
        s_nxt.count = s_r.hold;
      end else begin
        s_nxt.count = 8'h00;
      end
    end

    // Pulse level: high at cycle start, low once the count reaches reload
    if (ovf) begin
      s_nxt.pwm = 1'b1;
    end else if (match) begin
      s_nxt.pwm = 1'b0;
    end
    s_nxt.wake = ovf && s_r.clkopt[tcp_pkg::C_GN - 1] && low_power_mode;

    // Software writes; a count write beats the hardware step
    if (wr_en) begin
      case (s_r.didx)
        tcp_pkg::IDX_MODE:   s_nxt.mode   = hwdata[7:0];
        tcp_pkg::IDX_CLKOPT: s_nxt.clkopt = hwdata[3:1];
        tcp_pkg::IDX_COUNT:  s_nxt.count  = hwdata[7:0];
        tcp_pkg::IDX_RELOAD: s_nxt.hold   = hwdata[7:0];
        tcp_pkg::IDX_STATUS: s_nxt.ien    = hwdata[tcp_pkg::S_IEN];
        default:             s_nxt.ien    = s_r.ien;
      endcase
    end
    // Writing zero to the flag clears it, but a same-cycle overflow wins
    s_nxt.flag = ovf || (s_r.flag && !(wr_en && s_r.didx == tcp_pkg::IDX_STATUS
                                        && !hwdata[tcp_pkg::S_FLAG]));

    // Shared pin: pulse first, then tone, otherwise GPIO keeps it
    if (pwm_en) begin
      s_nxt.pin.o  = s_r.pwm;
      s_nxt.pin.oe = 1'b1;
    end else if (tone_en) begin
      s_nxt.pin.o  = s_r.tone;
      s_nxt.pin.oe = 1'b1;
    end else begin
      s_nxt.pin = gpio_pin;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r        <= '0;
      s_r.mode   <= tcp_pkg::MODE_RST;
      s_r.clkopt <= tcp_pkg::CLKOPT_RST;
      s_r.count  <= tcp_pkg::COUNT_RST;
      s_r.hold   <= tcp_pkg::RELOAD_RST;
      s_r.active <= tcp_pkg::RELOAD_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout          = 1'b1;
  assign hresp              = 1'b0;
  assign hrdata             = s_r.rdata;
  assign out_pin            = s_r.pin;
  assign wake_req           = s_r.wake;
  assign overflow_irq       = s_r.flag && s_r.ien;
  assign event_pin_irq_flag = event_irq_raw && !cks;
  assign event_wake_req     = event_wake_raw && !cks;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence evt_fall_seen;
    cks && enb ##1 !s_r.sync2 && s_r.sync3;
  endsequence

  a_evt_fall_count: assert property (evt_fall_seen |-> tick)
    else $error("falling edge in event mode did not count");
  a_stop_no_count: assert property (!enb |=> $stable(s_r.count) || $past(cnt_wr))
    else $error("count moved while disabled");
  a_flag_sticky: assert property (ovf |=> s_r.flag ##1 (s_r.flag || $past(wr_en)))
    else $error("overflow flag not held");
  a_reload_load: assert property (ovf && reload_on && !cnt_wr |=> s_r.count == $past(s_r.hold))
    else $error("count not reloaded on overflow");
  a_buf_transfer: assert property (ovf |=> s_r.active == $past(s_r.hold))
    else $error("reload buffer not taken over");
  a_bound_16: assert property (ovf && pwm_en && !cks && aload && tone_bit
                               |-> s_r.count[3:0] == 4'hf)
    else $error("pulse boundary 16 wrong");
  a_pwm_pin: assert property (pwm_en |=> out_pin.oe && out_pin.o == $past(s_r.pwm))
    else $error("pulse not on shared pin");
  a_tone_toggle: assert property (ovf |=> s_r.tone != $past(s_r.tone))
    else $error("tone did not toggle");
  a_evt_irq_mask: assert property (cks |-> !event_pin_irq_flag && !event_wake_req)
    else $error("event pin irq or wake not masked");
  a_irq_req: assert property (ovf && s_r.ien && !wr_en |=> overflow_irq)
    else $error("overflow did not request interrupt");

  // ----------------------------------------------------------------
  // Counting, pin and register checks
  // ----------------------------------------------------------------
  // Overflow while no reload applies and software leaves the count alone
  sequence ovf_no_reload;
    ovf && !reload_on && !cnt_wr;
  endsequence

  // Count meets the live reload inside a pulse cycle
  sequence pwm_match_seen;
    pwm_en && match && !ovf;
  endsequence

  // Register write in its data phase to one index
  sequence reg_write(logic [7:0] idx);
    wr_en && (s_r.didx == idx);
  endsequence

  // Plain step between overflows
  a_count_step: assert property (
    tick && !ovf && !cnt_wr |=> s_r.count == 8'($past(s_r.count) + 8'h01))
    else $error("count did not step by one");

  // Without reload the count restarts from zero
  a_no_reload: assert property (ovf_no_reload |=> s_r.count == 8'h00)
    else $error("count not cleared on overflow");

  // Pulse level drops once the count reaches the reload value
  a_pwm_fall: assert property (pwm_match_seen |=> !s_r.pwm)
    else $error("pulse level did not drop at match");

  // Every overflow starts a new pulse cycle high
  a_pwm_rise: assert property (ovf |=> s_r.pwm)
    else $error("pulse level not high after overflow");

  // Tone owns the pin only while pulse output is off
  a_tone_pin: assert property (
    !pwm_en && tone_bit |=> out_pin.oe && out_pin.o == $past(s_r.tone))
    else $error("tone not on shared pin");

  // With both outputs off the general I/O drive passes through
  a_gpio_pin: assert property (
    !pwm_en && !tone_bit |=> out_pin == $past(gpio_pin))
    else $error("shared pin not under general I/O");

  // Wake pulse follows an overflow in low-power mode
  a_wake_pulse: assert property (
    ovf && s_r.clkopt[tcp_pkg::C_GN - 1] && low_power_mode |=> wake_req)
    else $error("no wake pulse on overflow");

  // Mode register takes the written byte
  a_mode_write: assert property (
    reg_write(tcp_pkg::IDX_MODE) |=> s_r.mode == $past(hwdata[7:0]))
    else $error("mode write lost");

  // Clock option keeps only its three implemented bits
  a_clkopt_write: assert property (
    reg_write(tcp_pkg::IDX_CLKOPT) |=> s_r.clkopt == $past(hwdata[3:1]))
    else $error("clock option write lost");

  // Reload writes land in the holding buffer only
  a_hold_write: assert property (
    reg_write(tcp_pkg::IDX_RELOAD) |=> s_r.hold == $past(hwdata[7:0]))
    else $error("reload write not buffered");

  // Software clear of the flag works when no overflow competes
  a_flag_clear: assert property (
    wr_en && s_r.didx == tcp_pkg::IDX_STATUS && !hwdata[tcp_pkg::S_FLAG] && !ovf
    |=> !s_r.flag)
    else $error("overflow flag not cleared");

  // Event mode counts pin edges only; prescaler and fast select ignored
  a_evt_source: assert property (cks |-> tick == (enb && fall))
    else $error("event mode counted a wrong source");

  // Event mode always wraps at the full 8-bit value
  a_evt_wrap: assert property (cks && ovf |-> s_r.count == 8'hff)
    else $error("event overflow not at full value");

  // While stopped the live reload follows the buffer
  a_active_idle: assert property (!enb |=> s_r.active == $past(s_r.hold))
    else $error("idle reload not tracking buffer");

endmodule : tcp_timer

// ---- verif/tcp_evt_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Event source on the external input pin
// ----------------------------------------------------------------
module tcp_evt_model (
  input  wire logic       hclk,   // Paces the pulses
  input  wire logic       go,     // Start a burst
  input  wire logic [3:0] npulse, // Pulses in the burst
  output logic            evp,    // Event pin level
  output logic            busy    // Burst in progress
);
  // Pin idles high; each pulse stays low three cycles so that a
  // three-stage synchroniser cannot miss it
  initial begin
    evp  = 1'b1;
    busy = 1'b0;
  end

  // One burst of falling edges per request
  always begin
    @(posedge hclk);
    if (go === 1'b1) begin
      busy <= 1'b1;
      repeat (npulse) begin
        repeat (3) @(posedge hclk);
        evp <= 1'b0;
        repeat (3) @(posedge hclk);
        evp <= 1'b1;
      end
      busy <= 1'b0;
    end
  end
endmodule : tcp_evt_model

// ---- verif/testbench.sv ----
`timescale 1ns/1ps

module testbench;
  logic              hclk, hresetn, hsel, hwrite, hreadyout, hresp, fcpu_tick;
  logic [31:0]       haddr, hwdata, hrdata;
  logic [1:0]        htrans, tk;
  logic [2:0]        hsize;
  logic              ev_raw, wk_raw, lpm, evp, irqf, evw, ovi, wkq;
  logic              go, busy, rd_ph, prev, rise, wseen;
  logic [3:0]        npulse;
  tcp_pkg::tcp_pin_s gpio, opin;
  logic [31:0]       expq[$];
  int                error_cnt, checks;

  // ----------------------------------------------------------------
  // Clock, instruction tick, pin edge finder
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // Instruction clock is a quarter of the bus clock
  always @(posedge hclk) begin
    tk        <= tk + 2'h1;
    fcpu_tick <= (tk == 2'h3);
    prev      <= opin.o;
    if (wkq === 1'b1) wseen <= 1'b1;
  end
  assign rise = opin.o & ~prev;

  tcp_timer uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .fcpu_tick(fcpu_tick), .event_pin(evp), .event_irq_raw(ev_raw),
    .event_wake_raw(wk_raw), .low_power_mode(lpm), .gpio_pin(gpio),
    .out_pin(opin), .event_pin_irq_flag(irqf), .event_wake_req(evw),
    .overflow_irq(ovi), .wake_req(wkq));

  tcp_evt_model evm (.hclk(hclk), .go(go), .npulse(npulse), .evp(evp), .busy(busy));

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Read data is compared in its data phase against the oldest note
  always @(posedge hclk) if (rd_ph === 1'b1) chk(hrdata, expq.pop_front());

  // Single word transfer; hready is never assumed, only waited for
  task xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    rd_ph  <= ~w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_ph  <= 1'b0;
  endtask : xfer

  task wr(input logic [7:0] idx, input logic [31:0] d);
    xfer(1'b1, idx, d);
  endtask : wr

  task rd(input logic [7:0] idx, input logic [31:0] exp);
    expq.push_back(exp);
    xfer(1'b0, idx, 32'h0);
  endtask : rd

  // Burst of event edges, then the synchroniser delay
  task pulses(input logic [3:0] n);
    npulse <= n;
    go     <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    do @(posedge hclk); while (busy !== 1'b0);
    repeat (5) @(posedge hclk);
  endtask : pulses

  // Period between rises of the shared pin; the first two rises may
  // still belong to the previous setup, so the third one is measured
  task per(input int exp);
    int c;
    c = 0;
    repeat (2) do @(posedge hclk); while (rise !== 1'b1);
    do begin
      @(posedge hclk);
      c++;
    end while (rise !== 1'b1);
    chk(c, exp);
  endtask : per

  task results;
    $display("comparisons %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results

  // Longest run is about 40k cycles; two and a half times that means a hang
  initial begin
    #(100000 * 4);
    error_cnt++;
    results();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int ci;
    logic [7:0] v;
    void'($urandom(26));
    {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata, tk, fcpu_tick} = '0;
    {ev_raw, wk_raw, lpm, go, rd_ph, wseen} = 6'h38;
    npulse = 4'h0;
    gpio = '0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, unmapped place and write-only reload
    rd(tcp_pkg::IDX_MODE, 32'h0);
    rd(tcp_pkg::IDX_CLKOPT, 32'h0);
    rd(tcp_pkg::IDX_COUNT, 32'h0);
    rd(tcp_pkg::IDX_RELOAD, 32'h0);
    rd(8'h00, 32'h0);
    v = 8'($urandom) & 8'h77;
    wr(tcp_pkg::IDX_MODE, {24'h0, v});
    rd(tcp_pkg::IDX_MODE, {24'h0, v});
    wr(tcp_pkg::IDX_CLKOPT, 32'hffffffff);
    rd(tcp_pkg::IDX_CLKOPT, 32'h0e);
    v = 8'($urandom);
    wr(tcp_pkg::IDX_COUNT, {24'h0, v});
    rd(tcp_pkg::IDX_COUNT, {24'h0, v});
    wr(tcp_pkg::IDX_RELOAD, 32'h55);
    rd(tcp_pkg::IDX_RELOAD, 32'h0);
    // Shared pin follows general I/O while both outputs are off
    wr(tcp_pkg::IDX_MODE, 32'h0);
    gpio <= tcp_pkg::tcp_pin_s'($urandom);
    repeat (2) @(posedge hclk);
    chk({30'h0, opin}, {30'h0, gpio});
    chk({irqf, evw}, 2'b11);
    // Event counting with and without reload, wake in low power mode
    wr(tcp_pkg::IDX_CLKOPT, 32'h2);
    for (ci = 0; ci < 2; ci++) begin
      wr(tcp_pkg::IDX_MODE, {24'h0, 4'h0, 1'b1, ci[0], 2'b00});
      @(posedge hclk);
      chk({irqf, evw}, 2'b00);
      wr(tcp_pkg::IDX_RELOAD, 32'h10);
      wr(tcp_pkg::IDX_COUNT, 32'hfe);
      pulses(4'h2);
      rd(tcp_pkg::IDX_COUNT, 32'hfe);
      wr(tcp_pkg::IDX_STATUS, 32'h2);
      wseen <= 1'b0;
      wr(tcp_pkg::IDX_MODE, {24'h0, 4'h8, 1'b1, ci[0], 2'b00});
      pulses(4'h3);
      rd(tcp_pkg::IDX_COUNT, ci[0] ? 32'h11 : 32'h01);
      chk(ovi, 1'b1);
      chk(wseen, 1'b1);
      wr(tcp_pkg::IDX_STATUS, 32'h2);
      @(posedge hclk);
      chk(ovi, 1'b0);
    end
    // Every prescale code on the oscillator, most on the instruction clock
    wr(tcp_pkg::IDX_RELOAD, 32'h0);
    wr(tcp_pkg::IDX_COUNT, 32'h0);
    for (ci = 0; ci < 14; ci++) begin
      v = (ci < 8) ? ci[7:0] : ci[7:0] - 8'h6;
      wr(tcp_pkg::IDX_CLKOPT, {29'h0, ci < 8, 2'b00});
      wr(tcp_pkg::IDX_MODE, {24'h0, 1'b1, v[2:0], 4'h7});
      per((ci < 8) ? 16 << (7 - v) : 64 << (8 - v));
    end
    // Pulse-mode boundaries picked by reload and tone bits
    wr(tcp_pkg::IDX_CLKOPT, 32'h4);
    for (ci = 0; ci < 4; ci++) begin
      wr(tcp_pkg::IDX_MODE, {24'h0, 5'h1e, ci[1], ci[0], 1'b1});
      per((ci == 0) ? 256 : 256 >> (ci + 1));
      chk(opin.oe, 1'b1);
    end
    // Tone toggles once per overflow; then reload shortens the interval
    wr(tcp_pkg::IDX_MODE, 32'hf2);
    per(512);
    wr(tcp_pkg::IDX_RELOAD, 32'd256 - 32'd64);
    wr(tcp_pkg::IDX_MODE, 32'hf6);
    per(128);
    results();
  end
endmodule : testbench
